// [design/lbc_pkg.sv]
// constants and types shared by the brightness path
`default_nettype none
package lbc_pkg;

  localparam int unsigned CLK_KHZ = 250000;

  // register offsets
  localparam logic [7:0] ADDR_BRIGHT_CTRL = 8'h11;
  localparam logic [7:0] ADDR_PWM_CFG = 8'h12;
  localparam logic [7:0] ADDR_BOOST_CTRL = 8'h13;
  localparam logic [7:0] ADDR_BRIGHT_LOW = 8'h18;
  localparam logic [7:0] ADDR_BRIGHT_HIGH = 8'h19;
  localparam logic [7:0] ADDR_STATUS = 8'h1B;

  // field positions
  localparam int unsigned MODE_LSB = 5;
  localparam int unsigned RAMP_LSB = 1;
  localparam int unsigned RATE_LSB = 6;
  localparam int unsigned HYST_LSB = 2;
  localparam int unsigned FREQ_BIT = 5;
  localparam int unsigned SHIFT_BIT = 6;
  localparam int unsigned LOW_BITS = 3;

  // reset values
  localparam logic [7:0] RST_BRIGHT_CTRL = 8'h00;
  localparam logic [7:0] RST_PWM_CFG = 8'h00;
  localparam logic [7:0] RST_BOOST_CTRL = 8'h00;
  localparam logic [7:0] RST_BRIGHT_LOW = 8'h00;
  localparam logic [7:0] RST_BRIGHT_HIGH = 8'h00;

  localparam logic [10:0] FULL_DUTY = 11'h7FF;

  // pwm sample rates and timeouts
  localparam int unsigned RATE0_KHZ = 800;
  localparam int unsigned RATE1_KHZ = 4000;
  localparam int unsigned RATE2_KHZ = 24000;
  localparam int unsigned DIV0 = CLK_KHZ / RATE0_KHZ;
  localparam int unsigned DIV1 = CLK_KHZ / RATE1_KHZ;
  localparam int unsigned DIV2 = CLK_KHZ / RATE2_KHZ;
  localparam int unsigned TO0_US = 25000;
  localparam int unsigned TO1_US = 3000;
  localparam int unsigned TO2_US = 600;
  localparam int unsigned TO0_CYC = TO0_US * (CLK_KHZ / 1000);
  localparam int unsigned TO1_CYC = TO1_US * (CLK_KHZ / 1000);
  localparam int unsigned TO2_CYC = TO2_US * (CLK_KHZ / 1000);

  // ramp time per step in microseconds, selected by a 3 bit field
  localparam int unsigned RAMP_US [8] = '{1, 2, 4, 8, 16, 64, 256, 1000};

  // boost switching frequency
  localparam int unsigned FREQ_LO_KHZ = 500;
  localparam int unsigned FREQ_HI_KHZ = 1000;
  localparam int unsigned SHIFT_PCT = 12;
  localparam int unsigned FREQ_LO_SH_KHZ =
    FREQ_LO_KHZ * (100 - SHIFT_PCT) / 100;
  localparam int unsigned FREQ_HI_SH_KHZ =
    FREQ_HI_KHZ * (100 - SHIFT_PCT) / 100;

  typedef enum logic [1:0] {
    MODE_REG = 2'h0,
    MODE_PWM = 2'h1,
    MODE_MUL_RAMP = 2'h2,
    MODE_RAMP_MUL = 2'h3
  } lbc_mode_t;

  typedef enum logic [2:0] {
    DV_IDLE = 3'h1,
    DV_RUN = 3'h2,
    DV_DONE = 3'h4
  } lbc_div_t;

endpackage : lbc_pkg
`default_nettype wire

// [design/lbc_brightness_path.sv]
// brightness path: registers, pwm duty meter, ramper, boost controls
// What this block does
// - pwm timeout with pwm enabled turns boost off
// - timeout 25ms, 3ms, 0.6ms by sample rate
// - eight selectable ramp times per step
// - ramp lasts step time times (B-A-1)
// - fastest ramp moves min to max near 2ms
// - two bit field picks one of four modes
// - mode 00 uses registers only, pwm ignored
// - code is 3 low bits plus high byte
// - code commits only on high byte write
// - mode 00 ramps between register set-points
// - mode 01 ramps toward measured pwm duty code
// - mode 10 ramps toward register times duty
// - mode 11 ramps register code, then multiplies duty
// - boost control bit 5 picks 500kHz or 1MHz
// - boost control bit 6 lowers frequency 12%
// - pwm config bits 7:6 pick sample rate
// - hysteresis needs 2^n codes after reversal, 64 codes for n=7
`timescale 1ns/10ps
`default_nettype none
module lbc_brightness_path #(
  parameter int unsigned TO_CYC0 = lbc_pkg::TO0_CYC,
  parameter int unsigned TO_CYC1 = lbc_pkg::TO1_CYC,
  parameter int unsigned TO_CYC2 = lbc_pkg::TO2_CYC,
  parameter int unsigned RAMP_STEP_CYC [8] = '{
    lbc_pkg::RAMP_US[0] * (lbc_pkg::CLK_KHZ / 1000),
    lbc_pkg::RAMP_US[1] * (lbc_pkg::CLK_KHZ / 1000),
    lbc_pkg::RAMP_US[2] * (lbc_pkg::CLK_KHZ / 1000),
    lbc_pkg::RAMP_US[3] * (lbc_pkg::CLK_KHZ / 1000),
    lbc_pkg::RAMP_US[4] * (lbc_pkg::CLK_KHZ / 1000),
    lbc_pkg::RAMP_US[5] * (lbc_pkg::CLK_KHZ / 1000),
    lbc_pkg::RAMP_US[6] * (lbc_pkg::CLK_KHZ / 1000),
    lbc_pkg::RAMP_US[7] * (lbc_pkg::CLK_KHZ / 1000)}
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic PWM_IN,
  input wire logic REG_WR,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  output logic [10:0] BRIGHTNESS_CODE,
  output logic BOOST_ON,
  output logic [9:0] BOOST_FREQ_KHZ
);
  import lbc_pkg::*;

  // scale a code by a duty fraction, full duty passes it unchanged
  function automatic logic [10:0] scale_code(input logic [10:0] c,
                                             input logic [10:0] d);
    logic [21:0] p;
    p = c * d;
    scale_code = (d == FULL_DUTY) ? c : p[21:11];
  endfunction : scale_code

  // sample rate field to rate index, 1X both mean the fastest rate
  function automatic logic [1:0] rate_idx(input logic [1:0] f);
    rate_idx = f[1] ? 2'h2 : {1'b0, f[0]};
  endfunction : rate_idx

  ////////////////////////////////////////////////////////////////////////
  logic [7:0] ctrl_r, ctrl_nxt, cfg_r, cfg_nxt, boost_r, boost_nxt;
  logic [7:0] low_r, low_nxt, high_r, high_nxt, rdata_r, rdata_nxt;
  logic [10:0] reg_code_r, reg_code_nxt;
  logic [8:0] div_cnt_r, div_cnt_nxt, div_lim;
  logic pwm_last_r, pwm_last_nxt, seen_r, seen_nxt, tick, meas_go;
  logic [15:0] high_cnt_r, high_cnt_nxt, per_cnt_r, per_cnt_nxt;
  logic [22:0] to_cnt_r, to_cnt_nxt, to_lim;
  logic timeout_r, timeout_nxt;
  lbc_div_t st_r, st_nxt;
  logic [15:0] den_r, den_nxt;
  logic [16:0] rem_r, rem_nxt, rem2;
  logic [10:0] q_r, q_nxt, duty_r, duty_nxt, tgt, ramp_r, ramp_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [11:0] thr;
  logic dir_up_r, dir_up_nxt, ramping;
  logic [19:0] tmr_r, tmr_nxt, step_cyc;
  logic [10:0] code_r, code_nxt;
  logic boost_on_r, boost_on_nxt;
  logic [9:0] freq_r, freq_nxt;
  lbc_mode_t mode;
  logic pwm_en;
  logic [2:0] hyst;

  assign mode = lbc_mode_t'(ctrl_r[MODE_LSB +: 2]);
  assign pwm_en = (mode != MODE_REG);
  assign hyst = cfg_r[HYST_LSB +: 3];
  assign step_cyc = 20'(RAMP_STEP_CYC[ctrl_r[RAMP_LSB +: 3]]);

  ////////////////////////////////////////////////////////////////////////
  // register writes and registered read data
  always_comb begin
    ctrl_nxt = ctrl_r;
    cfg_nxt = cfg_r;
    boost_nxt = boost_r;
    low_nxt = low_r;
    high_nxt = high_r;
    reg_code_nxt = reg_code_r;
    if (REG_WR) begin
      unique case (REG_ADDR)
        ADDR_BRIGHT_CTRL: ctrl_nxt = REG_WDATA;
        ADDR_PWM_CFG: cfg_nxt = REG_WDATA;
        ADDR_BOOST_CTRL: boost_nxt = REG_WDATA;
        ADDR_BRIGHT_LOW: low_nxt = REG_WDATA; // held, no effect yet
        ADDR_BRIGHT_HIGH: begin
          high_nxt = REG_WDATA;
          reg_code_nxt = {REG_WDATA, low_r[LOW_BITS-1:0]};
        end
        default: ;
      endcase
    end
    unique case (REG_ADDR)
      ADDR_BRIGHT_CTRL: rdata_nxt = ctrl_r;
      ADDR_PWM_CFG: rdata_nxt = cfg_r;
      ADDR_BOOST_CTRL: rdata_nxt = boost_r;
      ADDR_BRIGHT_LOW: rdata_nxt = low_r;
      ADDR_BRIGHT_HIGH: rdata_nxt = high_r;
      ADDR_STATUS: rdata_nxt = {6'h00, ramping, timeout_r};
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_r <= RST_BRIGHT_CTRL;
      cfg_r <= RST_PWM_CFG;
      boost_r <= RST_BOOST_CTRL;
      low_r <= RST_BRIGHT_LOW;
      high_r <= RST_BRIGHT_HIGH;
      reg_code_r <= 11'h000;
      rdata_r <= 8'h00;
    end else if (CE) begin
      ctrl_r <= ctrl_nxt;
      cfg_r <= cfg_nxt;
      boost_r <= boost_nxt;
      low_r <= low_nxt;
      high_r <= high_nxt;
      reg_code_r <= reg_code_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pwm sampler, period and high-time counters, timeout
  always_comb begin
    unique case (rate_idx(cfg_r[RATE_LSB +: 2]))
      2'h0: begin
        div_lim = 9'(DIV0);
        to_lim = 23'(TO_CYC0);
      end
      2'h1: begin
        div_lim = 9'(DIV1);
        to_lim = 23'(TO_CYC1);
      end
      default: begin
        div_lim = 9'(DIV2);
        to_lim = 23'(TO_CYC2);
      end
    endcase
    tick = (div_cnt_r >= div_lim - 9'h001);
    div_cnt_nxt = tick ? 9'h000 : div_cnt_r + 9'h001;
    pwm_last_nxt = pwm_last_r;
    high_cnt_nxt = high_cnt_r;
    per_cnt_nxt = per_cnt_r;
    seen_nxt = seen_r;
    meas_go = 1'b0;
    if (tick) begin
      pwm_last_nxt = PWM_IN;
      if (PWM_IN && !pwm_last_r) begin
        meas_go = seen_r && pwm_en;
        seen_nxt = 1'b1;
        high_cnt_nxt = 16'h0001;
        per_cnt_nxt = 16'h0001;
      end else begin
        if (per_cnt_r != 16'hFFFF) per_cnt_nxt = per_cnt_r + 16'h0001;
        if (PWM_IN && high_cnt_r != 16'hFFFF)
          high_cnt_nxt = high_cnt_r + 16'h0001;
      end
    end
    to_cnt_nxt = to_cnt_r;
    timeout_nxt = timeout_r;
    if (!pwm_en || (tick && PWM_IN)) begin
      to_cnt_nxt = 23'h000000;
      timeout_nxt = 1'b0;
    end else if (to_cnt_r >= to_lim - 23'h000001) begin
      timeout_nxt = 1'b1;
    end else begin
      to_cnt_nxt = to_cnt_r + 23'h000001;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      div_cnt_r <= 9'h000;
      pwm_last_r <= 1'b0;
      seen_r <= 1'b0;
      high_cnt_r <= 16'h0000;
      per_cnt_r <= 16'h0000;
      to_cnt_r <= 23'h000000;
      timeout_r <= 1'b0;
    end else if (CE) begin
      div_cnt_r <= div_cnt_nxt;
      pwm_last_r <= pwm_last_nxt;
      seen_r <= seen_nxt;
      high_cnt_r <= high_cnt_nxt;
      per_cnt_r <= per_cnt_nxt;
      to_cnt_r <= to_cnt_nxt;
      timeout_r <= timeout_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // duty divider: high time over period, 11 bit fraction
  always_comb begin
    st_nxt = st_r;
    den_nxt = den_r;
    rem_nxt = rem_r;
    q_nxt = q_r;
    bit_nxt = bit_r;
    rem2 = {rem_r[15:0], 1'b0};
    unique case (st_r)
      DV_IDLE: if (meas_go) begin
        den_nxt = per_cnt_r;
        rem_nxt = {1'b0, high_cnt_r};
        q_nxt = 11'h000;
        bit_nxt = 4'h0;
        if (high_cnt_r >= per_cnt_r) begin
          q_nxt = FULL_DUTY;
          st_nxt = DV_DONE;
        end else begin
          st_nxt = DV_RUN;
        end
      end
      DV_RUN: begin
        if (rem2 >= {1'b0, den_r}) begin
          rem_nxt = rem2 - {1'b0, den_r};
          q_nxt = {q_r[9:0], 1'b1};
        end else begin
          rem_nxt = rem2;
          q_nxt = {q_r[9:0], 1'b0};
        end
        bit_nxt = bit_r + 4'h1;
        if (bit_r == 4'hA) st_nxt = DV_DONE;
      end
      DV_DONE: st_nxt = DV_IDLE;
      default: st_nxt = DV_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      st_r <= DV_IDLE;
      den_r <= 16'h0000;
      rem_r <= 17'h00000;
      q_r <= 11'h000;
      bit_r <= 4'h0;
    end else if (CE) begin
      st_r <= st_nxt;
      den_r <= den_nxt;
      rem_r <= rem_nxt;
      q_r <= q_nxt;
      bit_r <= bit_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // duty hysteresis: a reversal must reach the threshold first
  always_comb begin
    duty_nxt = duty_r;
    dir_up_nxt = dir_up_r;
    thr = 12'h001 << ((hyst == 3'h7) ? 3'h6 : hyst);
    if (st_r == DV_DONE) begin
      if (q_r > duty_r) begin
        if (dir_up_r || {1'b0, q_r - duty_r} >= thr) begin
          duty_nxt = q_r;
          dir_up_nxt = 1'b1;
        end
      end else if (q_r < duty_r) begin
        if (!dir_up_r || {1'b0, duty_r - q_r} >= thr) begin
          duty_nxt = q_r;
          dir_up_nxt = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      duty_r <= 11'h000;
      dir_up_r <= 1'b1;
    end else if (CE) begin
      duty_r <= duty_nxt;
      dir_up_r <= dir_up_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // ramp target by mode and one-code-per-step ramper
  always_comb begin
    unique case (mode)
      MODE_REG: tgt = reg_code_r;
      MODE_PWM: tgt = duty_r;
      MODE_MUL_RAMP: tgt = scale_code(reg_code_r, duty_r);
      MODE_RAMP_MUL: tgt = reg_code_r;
    endcase
    ramping = (ramp_r != tgt);
    ramp_nxt = ramp_r;
    tmr_nxt = tmr_r;
    if (!ramping) begin
      tmr_nxt = 20'h00000;
    end else if (tmr_r == 20'h00000) begin
      // first step is immediate, so B-A steps span (B-A-1) periods
      ramp_nxt = (tgt > ramp_r) ? ramp_r + 11'h001 : ramp_r - 11'h001;
      tmr_nxt = step_cyc - 20'h00001;
    end else begin
      tmr_nxt = tmr_r - 20'h00001;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ramp_r <= 11'h000;
      tmr_r <= 20'h00000;
    end else if (CE) begin
      ramp_r <= ramp_nxt;
      tmr_r <= tmr_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output code, boost enable and switching frequency
  always_comb begin
    code_nxt = (mode == MODE_RAMP_MUL) ? scale_code(ramp_r, duty_r)
                                       : ramp_r;
    boost_on_nxt = !(pwm_en && timeout_r);
    unique case ({boost_r[SHIFT_BIT], boost_r[FREQ_BIT]})
      2'h0: freq_nxt = 10'(FREQ_LO_KHZ);
      2'h1: freq_nxt = 10'(FREQ_HI_KHZ);
      2'h2: freq_nxt = 10'(FREQ_LO_SH_KHZ);
      2'h3: freq_nxt = 10'(FREQ_HI_SH_KHZ);
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      code_r <= 11'h000;
      boost_on_r <= 1'b1;
      freq_r <= 10'h000;
    end else if (CE) begin
      code_r <= code_nxt;
      boost_on_r <= boost_on_nxt;
      freq_r <= freq_nxt;
    end
  end

  assign BRIGHTNESS_CODE = code_r;
  assign BOOST_ON = boost_on_r;
  assign BOOST_FREQ_KHZ = freq_r;
  assign REG_RDATA = rdata_r;

  ////////////////////////////////////////////////////////////////////////
  // checks on the brightness path
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  property p_boost_off;
    CE && pwm_en && timeout_r |=> !BOOST_ON;
  endproperty
  a_boost_off: assert property (p_boost_off)
    else $error("boost on during pwm timeout");

  property p_timeout_lim;
    CE && !timeout_r && timeout_nxt |-> to_cnt_r == to_lim - 23'h000001;
  endproperty
  a_timeout_lim: assert property (p_timeout_lim)
    else $error("timeout set at wrong count");

  property p_step_gap;
    $changed(ramp_r) |-> $past(tmr_r) == 20'h00000 &&
      tmr_r == $past(step_cyc) - 20'h00001;
  endproperty
  a_step_gap: assert property (p_step_gap)
    else $error("ramp stepped off its timer");

  property p_step_one;
    $changed(ramp_r) |-> (ramp_r == $past(ramp_r) + 11'h001) ||
      (ramp_r == $past(ramp_r) - 11'h001);
  endproperty
  a_step_one: assert property (p_step_one)
    else $error("ramp moved more than one code");

  property p_mode_reg;
    CE && mode == MODE_REG |=> BRIGHTNESS_CODE == $past(ramp_r);
  endproperty
  a_mode_reg: assert property (p_mode_reg)
    else $error("mode 00 output differs from ramp");

  property p_hi_commit;
    CE && REG_WR && REG_ADDR == ADDR_BRIGHT_HIGH |=>
      reg_code_r == {$past(REG_WDATA), $past(low_r[2:0])};
  endproperty
  a_hi_commit: assert property (p_hi_commit)
    else $error("high byte write did not commit code");

  property p_low_hold;
    CE && REG_WR && REG_ADDR == ADDR_BRIGHT_LOW |=> $stable(reg_code_r);
  endproperty
  a_low_hold: assert property (p_low_hold)
    else $error("low write changed brightness code");

  property p_pwm_follow;
    CE && mode == MODE_PWM && ramp_r < duty_r && tmr_r == 20'h00000 |=>
      ramp_r == $past(ramp_r) + 11'h001;
  endproperty
  a_pwm_follow: assert property (p_pwm_follow)
    else $error("mode 01 ramp not moving to duty");

  property p_mode_rm;
    CE && mode == MODE_RAMP_MUL |=>
      BRIGHTNESS_CODE == scale_code($past(ramp_r), $past(duty_r));
  endproperty
  a_mode_rm: assert property (p_mode_rm)
    else $error("mode 11 output not ramp times duty");

  property p_freq;
    CE && boost_r[FREQ_BIT] && boost_r[SHIFT_BIT] |=>
      BOOST_FREQ_KHZ == 10'(FREQ_HI_SH_KHZ);
  endproperty
  a_freq: assert property (p_freq)
    else $error("shifted 1MHz frequency wrong");

  property p_full;
    CE && mode == MODE_RAMP_MUL && duty_r == FULL_DUTY |=>
      BRIGHTNESS_CODE == $past(ramp_r);
  endproperty
  a_full: assert property (p_full)
    else $error("full duty changed the code");

  c_timeout: cover property (pwm_en && timeout_r && !BOOST_ON);
  c_ramp_done: cover property ($fell(ramping));
  c_reversal: cover property (st_r == DV_DONE && dir_up_r && !dir_up_nxt);

endmodule : lbc_brightness_path
`default_nettype wire

// [verification/lbc_pwm_source.sv]
// pwm source model that feeds the dimming input of the brightness path
`timescale 1ns/10ps
`default_nettype none
module lbc_pwm_source (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [15:0] period_cyc,
  input wire logic [15:0] high_cyc,
  output logic pwm_out
);
  int cnt;
  logic [15:0] high_now;

  initial begin
    cnt = 0;
    high_now = 16'h0000;
    pwm_out = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // a new high time is taken only at a period start, so periods stay whole
  // stopped source idles low: no pulse at all, as a dead driver would
  always @(posedge clock) begin
    #1;
    if (!rst_n || !run) begin
      cnt = 0;
      pwm_out = 1'b0;
    end else begin
      if (cnt == 0) high_now = high_cyc;
      pwm_out = (cnt < high_now);
      cnt = (cnt + 1 >= period_cyc) ? 0 : cnt + 1;
    end
  end
endmodule : lbc_pwm_source
`default_nettype wire

// [verification/test_led_brightness_control_path.sv]
// self-checking bench for the brightness path with a reference model
`timescale 1ns/10ps
`default_nettype none
module test_led_brightness_control_path;
  import lbc_pkg::*;
  localparam int unsigned TO_LIST [3] = '{2000, 400, 100};
  localparam int unsigned DIV_LIST [3] = '{DIV0, DIV1, DIV2};
  localparam int unsigned STEP_LIST [8] = '{1, 2, 3, 4, 5, 6, 7, 8};
  logic CLOCK, RST_N, CE, PWM_IN, REG_WR, BOOST_ON, src_run;
  logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA;
  logic [10:0] BRIGHTNESS_CODE;
  logic [9:0] BOOST_FREQ_KHZ;
  logic [15:0] src_period, src_high;
  logic [7:0] mreg [256];
  int bad_count, checks_done, elapsed, reg_code, duty, a_code, b_code;
  int ti, fq, d;

  lbc_brightness_path #(.TO_CYC0(TO_LIST[0]), .TO_CYC1(TO_LIST[1]),
    .TO_CYC2(TO_LIST[2]), .RAMP_STEP_CYC(STEP_LIST)) dut (.CLOCK(CLOCK),
    .RST_N(RST_N), .CE(CE), .PWM_IN(PWM_IN), .REG_WR(REG_WR),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .BRIGHTNESS_CODE(BRIGHTNESS_CODE), .BOOST_ON(BOOST_ON),
    .BOOST_FREQ_KHZ(BOOST_FREQ_KHZ));

  lbc_pwm_source src (.clock(CLOCK), .rst_n(RST_N), .run(src_run),
    .period_cyc(src_period), .high_cyc(src_high), .pwm_out(PWM_IN));

  initial begin
    CLOCK = 1'b0;
    forever #2 CLOCK = ~CLOCK;
  end

  ////////////////////////////////////////////////////////////////////////
  // verdict and comparisons
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic fail(input string msg);
    bad_count++;
    $display("mismatch at %0t: %s", $time, msg);
  endtask : fail

  task automatic cmp_code(input logic [10:0] got, input int exp);
    checks_done++;
    if (got !== 11'(exp)) fail($sformatf("code %0d want %0d", got, exp));
  endtask : cmp_code

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) fail($sformatf("read %h want %h", got, exp));
  endtask : cmp_byte

  task automatic cmp_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) fail($sformatf("flag %b want %b", got, exp));
  endtask : cmp_bit

  task automatic cmp_freq(input logic [9:0] got, input int exp);
    checks_done++;
    if (got !== 10'(exp)) fail($sformatf("freq %0d want %0d", got, exp));
  endtask : cmp_freq

  task automatic cmp_span(input int got, input int lo, input int hi);
    checks_done++;
    if (got < lo || got > hi) fail($sformatf("took %0d cycles", got));
  endtask : cmp_span

  ////////////////////////////////////////////////////////////////////////
  // reference model of codes and duty
  function automatic int exp_code(input int mode, input int rc, input int dt);
    if (mode == 0) return rc;
    if (mode == 1) return dt;
    if (dt >= 2047) return rc;
    return rc * dt / 2048;
  endfunction : exp_code

  function automatic int exp_duty(input int hi, input int per);
    return (hi >= per) ? 2047 : hi * 2048 / per;
  endfunction : exp_duty

  function automatic logic [7:0] ctrl(input int mode, input int rate);
    return 8'((mode << MODE_LSB) | (rate << RAMP_LSB));
  endfunction : ctrl

  ////////////////////////////////////////////////////////////////////////
  // register access and bounded waits
  task automatic cyc(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge CLOCK) #1;
    REG_WR = 1'b1;
    REG_ADDR = addr;
    REG_WDATA = data;
    @(posedge CLOCK) #1;
    REG_WR = 1'b0;
    if (addr inside {ADDR_BRIGHT_CTRL, ADDR_PWM_CFG, ADDR_BOOST_CTRL,
        ADDR_BRIGHT_LOW, ADDR_BRIGHT_HIGH}) mreg[addr] = data;
  endtask : wr

  task automatic rd_chk(input logic [7:0] addr);
    @(posedge CLOCK) #1;
    REG_ADDR = addr;
    cyc(1);
    cmp_byte(REG_RDATA, mreg[addr]);
  endtask : rd_chk

  // low bits first, then the high byte that commits the code
  task automatic set_bright(input int code);
    wr(ADDR_BRIGHT_LOW, 8'(code & 7));
    wr(ADDR_BRIGHT_HIGH, 8'(code >> 3));
    reg_code = code;
  endtask : set_bright

  task automatic wait_code(input int exp, input int bound);
    elapsed = 0;
    while (BRIGHTNESS_CODE !== 11'(exp)) begin
      cyc(1);
      elapsed++;
      if (elapsed > bound) begin
        fail("brightness code never settled");
        tally_and_finish();
      end
    end
    cmp_code(BRIGHTNESS_CODE, exp);
  endtask : wait_code

  task automatic wait_boost(input logic exp, input int bound);
    elapsed = 0;
    while (BOOST_ON !== exp) begin
      cyc(1);
      elapsed++;
      if (elapsed > bound) begin
        fail("boost enable never changed");
        tally_and_finish();
      end
    end
    cmp_bit(BOOST_ON, exp);
  endtask : wait_boost

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    RST_N = 1'b0;
    CE = 1'b1;
    REG_WR = 1'b0;
    REG_ADDR = 8'h00;
    REG_WDATA = 8'h00;
    src_run = 1'b0;
    src_period = 16'(1000);
    src_high = 16'(250);
    bad_count = 0;
    checks_done = 0;
    reg_code = 0;
    foreach (mreg[i]) mreg[i] = 8'h00;
    void'($urandom(61159));
    repeat (5) @(posedge CLOCK);
    #1 RST_N = 1'b1;
    cyc(2);
    cmp_code(BRIGHTNESS_CODE, 0);
    cmp_bit(BOOST_ON, 1'b1);
    cmp_freq(BOOST_FREQ_KHZ, FREQ_LO_KHZ);
    wr(8'h05, 8'hA5);
    foreach (mreg[a]) if (a inside {8'h05, 8'h11, 8'h12, 8'h13, 8'h18,
        8'h19}) rd_chk(8'(a));
    // every frequency and shift combination
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_BOOST_CTRL, 8'(i << FREQ_BIT));
      cyc(2);
      fq = i[0] ? FREQ_HI_KHZ : FREQ_LO_KHZ;
      if (i[1]) fq = fq * (100 - SHIFT_PCT) / 100;
      cmp_freq(BOOST_FREQ_KHZ, fq);
      rd_chk(ADDR_BOOST_CTRL);
    end
    // register mode ramps at every rate while pwm pulses are ignored
    src_run = 1'b1;
    a_code = 0;
    for (int r = 0; r < 8; r++) begin
      wr(ADDR_BRIGHT_CTRL, ctrl(0, r));
      b_code = a_code + 6 + $urandom_range(3);
      wr(ADDR_BRIGHT_LOW, 8'(b_code & 7));
      cyc(4);
      cmp_code(BRIGHTNESS_CODE, a_code);
      wr(ADDR_BRIGHT_HIGH, 8'(b_code >> 3));
      wait_code(exp_code(0, b_code, 0), 200);
      d = (b_code - a_code - 1) * STEP_LIST[r];
      cmp_span(elapsed, d + 1, d + 3);
      rd_chk(ADDR_BRIGHT_LOW);
      rd_chk(ADDR_BRIGHT_HIGH);
      a_code = b_code;
    end
    reg_code = a_code;
    // pwm only, register code ignored
    wr(ADDR_PWM_CFG, 8'(2 << RATE_LSB));
    wr(ADDR_BRIGHT_CTRL, ctrl(1, 0));
    duty = exp_duty(250, 1000);
    wait_code(exp_code(1, reg_code, duty), 8000);
    set_bright(1024);
    cyc(20);
    cmp_code(BRIGHTNESS_CODE, exp_code(1, reg_code, duty));
    // multiply then ramp
    wr(ADDR_BRIGHT_CTRL, ctrl(2, 0));
    wait_code(exp_code(2, reg_code, duty), 3000);
    src_high = 16'(990);
    duty = exp_duty(990, 1000);
    wait_code(exp_code(2, reg_code, duty), 5000);
    // ramp then multiply: duty steps skip the slow ramp
    wr(ADDR_BRIGHT_CTRL, ctrl(3, 7));
    wait_code(exp_code(3, reg_code, duty), 2000);
    src_high = 16'(250);
    duty = exp_duty(250, 1000);
    wait_code(exp_code(3, reg_code, duty), 3000);
    set_bright(1040);
    wait_code(exp_code(3, reg_code, duty), 400);
    // hysteresis of 32 codes: a 20 code reversal is held, 40 codes pass
    wr(ADDR_PWM_CFG, 8'((2 << RATE_LSB) | (5 << HYST_LSB)));
    src_high = 16'(260);
    cyc(2200);
    cmp_code(BRIGHTNESS_CODE, exp_code(3, reg_code, duty));
    src_high = 16'(270);
    duty = exp_duty(270, 1000);
    wait_code(exp_code(3, reg_code, duty), 3000);
    // timeout at each sample rate setting, pwm held high then stopped
    src_high = 16'(1000);
    cyc(1100);
    for (int r = 0; r < 4; r++) begin
      ti = (r > 2) ? 2 : r;
      wr(ADDR_PWM_CFG, 8'(r << RATE_LSB));
      cyc(2 * DIV_LIST[ti]);
      cmp_bit(BOOST_ON, 1'b1);
      src_run = 1'b0;
      wait_boost(1'b0, TO_LIST[ti] + 50);
      d = TO_LIST[ti] - DIV_LIST[ti];
      cmp_span(elapsed, d, TO_LIST[ti] + 5);
      REG_ADDR = ADDR_STATUS;
      cyc(2);
      cmp_bit(REG_RDATA[0], 1'b1);
      src_run = 1'b1;
      wait_boost(1'b1, DIV_LIST[ti] + 6);
    end
    tally_and_finish();
  end
endmodule : test_led_brightness_control_path
`default_nettype wire
